// file: src/dmsc_top.sv
// Setup command block: AHB-Lite registers, control port switch, touch, backlight, notify
//
// Notes on behaviour
// - Binary notify setting 1 gives fixed binary notifications; setting readable back.
// - Binary notify setting 0 gives text notifications per the notify formats.
// - Binary state notification is S, index byte, state byte, no return.
// - Panel query returns panel identity, or config string when one is defined.
// - Exactly one serial port is the control port; only it passes commands.
// - Three escape characters in a row on the inactive port switch control there.
// - Escape character resets to 0x0d, settable 0x01 to 0x7e, readable back.
// - Select main or aux switches at once and stores the choice persistently.
// - Revert returns control to the port active before the last escape switch.
// - Typematic delay and repeat are 0 to 255 in 10 ms units, stored.
// - Touches ignored for debounce milliseconds after one; default 100, readable.
// - Orientation code upper bit drives first flip output, lower bit second.
// - Backlight enable is high for on when polarity is 1, else low.
// - Touch axis exchange 0 uses signals as given, 1 swaps X and Y.
// - PWM class picks high frequency or low frequency backlight PWM.
// - Brightness limits 0 to 255; their order sets the control polarity.
// - Touch options lockout, pressure and wander combine freely.
// - Touch accepted after the set sample count all fall inside the span.
// - Calibration waits for a touch at most the set number of seconds.
// - Config string query returns the string without its quotes.
`default_nettype none
module dmsc_top
	import dmsc_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF,
	parameter logic [31:0] PANEL_ID = 32'h0000a5a5,
	parameter logic CONFIG_SET = 1'b0,
	parameter logic [31:0] CONFIG_WORD = 32'h00000000
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic main_rx_valid,
	input wire logic [7:0] main_rx_data,
	input wire logic aux_rx_valid,
	input wire logic [7:0] aux_rx_data,
	output logic cmd_valid,
	output logic [7:0] cmd_data,
	output logic ctl_port_aux,
	output logic nv_store,
	input wire logic note_valid,
	input wire logic [7:0] note_kind,
	input wire logic [7:0] note_index,
	input wire logic note_has_state,
	input wire logic [7:0] note_state,
	output logic note_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic touch_sample,
	input wire logic touch_down,
	input wire logic touch_pressure_ok,
	input wire logic [9:0] touch_x,
	input wire logic [9:0] touch_y,
	output logic touch_valid,
	output logic touch_release,
	output logic touch_lockout,
	output logic [9:0] touch_pos_x,
	output logic [9:0] touch_pos_y,
	input wire logic cal_start,
	output logic cal_timeout,
	input wire logic backlight_on,
	output logic backlight_en,
	output logic backlight_pwm,
	output logic panel_flip_a,
	output logic panel_flip_b
);
	typedef struct packed {
		logic rdy, dwr;
		logic [7:0] dadr;
		logic [31:0] rd;
		logic bin, swap, pol, pcls;
		logic [1:0] orient;
		logic [3:0] tmode;
		logic [7:0] esc;
		logic act, stored, prev, temp;
		logic [1:0] ecnt;
		logic [7:0] tdly, trep;
		logic [15:0] deb;
		logic [7:0] bmax, bmin, bcmd, smp, span, calto;
		logic nv, cv;
		logic [7:0] cd;
		logic [17:0] msdiv;
		logic tick;
		logic [15:0] dbc;
		logic [7:0] scnt;
		logic [9:0] rx, ry, px, py;
		logic held, tv, trel, lock;
		logic cact;
		logic [9:0] cms;
		logic [7:0] csec;
		logic cto;
		logic [7:0] lvl, pcnt, ppre;
		logic pwm, blen, fa, fb;
		logic [8:0][7:0] nb;
		logic [3:0] nlen, nptr;
		logic txv;
		logic [7:0] txd;
		logic nrdy;
	} dmsc_state_t;

	dmsc_state_t st, nx;
	logic wr_en, wr_esc, do_rev;
	logic [31:0] rmux;
	logic in_v, in_aux;
	logic [7:0] in_d;
	logic [9:0] sx, sy, dx, dy;
	logic [16:0] lvl_calc;
	logic [7:0] upper;
	int k;

	function automatic logic [7:0] dig(input logic [7:0] v);
		dig = CH_ZERO + v;
	endfunction

	always_comb begin
		nx = st;
		k = 0;
		wr_en = st.dwr;
		wr_esc = 1'b0;
		do_rev = 1'b0;
		nx.nv = 1'b0;
		nx.cv = 1'b0;
		nx.tv = 1'b0;
		nx.trel = 1'b0;
		nx.cto = 1'b0;
		nx.tick = 1'b0;
		// Zero wait state slave, always OKAY
		nx.rdy = 1'b1;
		rmux = 32'h0;
		unique case (haddr[7:0])
			OFS_CTRL: rmux = {20'h0, st.tmode, 2'h0, st.orient, st.pcls, st.pol,
				st.swap, st.bin};
			OFS_PORT: rmux = {29'h0, st.temp, st.stored, st.act};
			OFS_ESC: rmux = {24'h0, st.esc};
			OFS_TYPEMATIC: rmux = {16'h0, st.trep, st.tdly};
			OFS_DEBOUNCE: rmux = {16'h0, st.deb};
			OFS_BRIGHT: rmux = {st.lvl, st.bcmd, st.bmin, st.bmax};
			OFS_TOUCH: rmux = {8'h0, st.calto, st.span, st.smp};
			OFS_PANEL: rmux = CONFIG_SET ? CONFIG_WORD : PANEL_ID;
			OFS_CONFIG: rmux = CONFIG_WORD;
			default: rmux = 32'h0;
		endcase
		nx.dwr = 1'b0;
		if (hsel && hready && htrans[1]) begin
			nx.dwr = hwrite;
			nx.dadr = haddr[7:0];
			nx.rd = hwrite ? 32'h0 : rmux;
		end
		if (wr_en) begin
			unique case (st.dadr)
				OFS_CTRL: begin
					nx.bin = hwdata[CTRL_BIN];
					nx.swap = hwdata[CTRL_SWAP];
					nx.pol = hwdata[CTRL_POL];
					nx.pcls = hwdata[CTRL_PWMCLS];
					nx.orient = hwdata[CTRL_ORIENT+:2];
					nx.tmode = hwdata[CTRL_TMODE+:4];
					nx.nv = 1'b1;
				end
				OFS_PORT: begin
					if (hwdata[PC_MAIN] || hwdata[PC_AUX]) begin
						nx.act = hwdata[PC_AUX];
						nx.stored = hwdata[PC_AUX];
						nx.temp = 1'b0;
						nx.nv = 1'b1;
					end else if (hwdata[PC_REVERT] && st.temp) begin
						do_rev = 1'b1;
						nx.act = st.prev;
						nx.temp = 1'b0;
					end
				end
				OFS_ESC: begin
					wr_esc = 1'b1;
					if (hwdata[7:0] >= ESC_MIN && hwdata[7:0] <= ESC_MAX) begin
						nx.esc = hwdata[7:0];
						nx.nv = 1'b1;
					end
				end
				OFS_TYPEMATIC: begin
					nx.tdly = hwdata[7:0];
					nx.trep = hwdata[15:8];
					nx.nv = 1'b1;
				end
				OFS_DEBOUNCE: begin
					nx.deb = hwdata[15:0];
					nx.nv = 1'b1;
				end
				OFS_BRIGHT: begin
					nx.bmax = hwdata[7:0];
					nx.bmin = hwdata[15:8];
					nx.bcmd = hwdata[23:16];
					nx.nv = 1'b1;
				end
				OFS_TOUCH: begin
					nx.smp = hwdata[7:0];
					nx.span = hwdata[15:8];
					nx.calto = hwdata[23:16];
					nx.nv = 1'b1;
				end
				default: nx.nv = 1'b0;
			endcase
		end
		// Active port bytes pass; inactive port bytes only feed the escape count
		if (main_rx_valid && !st.act) begin
			nx.cv = 1'b1;
			nx.cd = main_rx_data;
		end
		if (aux_rx_valid && st.act) begin
			nx.cv = 1'b1;
			nx.cd = aux_rx_data;
		end
		in_aux = !st.act;
		in_v = in_aux ? aux_rx_valid : main_rx_valid;
		in_d = in_aux ? aux_rx_data : main_rx_data;
		if (in_v && !wr_en) begin
			if (in_d != st.esc) begin
				nx.ecnt = 2'h0;
			end else if (st.ecnt == ESC_RUN_LAST) begin
				nx.ecnt = 2'h0;
				nx.prev = st.act;
				nx.act = in_aux;
				nx.temp = 1'b1;
			end else begin
				nx.ecnt = st.ecnt + 2'h1;
			end
		end
		// Millisecond tick shared by debounce and calibration
		nx.msdiv = st.msdiv + 18'h1;
		if (st.msdiv == 18'(MS_CYCLES - 1)) begin
			nx.msdiv = 18'h0;
			nx.tick = 1'b1;
		end
		if (st.tick && st.dbc != 16'h0) begin
			nx.dbc = st.dbc - 16'h1;
		end
		// Axis exchange happens before any position test
		sx = st.swap ? touch_y : touch_x;
		sy = st.swap ? touch_x : touch_y;
		dx = (sx > st.rx) ? sx - st.rx : st.rx - sx;
		dy = (sy > st.ry) ? sy - st.ry : st.ry - sy;
		if (!touch_down) begin
			nx.scnt = 8'h0;
			nx.lock = 1'b0;
			if (st.held) begin
				nx.held = 1'b0;
				nx.trel = 1'b1;
			end
		end else if (touch_sample) begin
			if (st.held) begin
				if (st.tmode[TM_W] && (dx > 10'(st.span) || dy > 10'(st.span))) begin
					nx.held = 1'b0;
					nx.trel = 1'b1;
					nx.lock = 1'b0;
				end
			end else if (st.scnt == 8'h0 || dx > 10'(st.span) || dy > 10'(st.span)) begin
				nx.rx = sx;
				nx.ry = sy;
				nx.scnt = 8'h1;
			end else if (st.scnt + 8'h1 < st.smp) begin
				nx.scnt = st.scnt + 8'h1;
			end else if (st.dbc == 16'h0 && (!st.tmode[TM_P] || touch_pressure_ok)) begin
				nx.tv = 1'b1;
				nx.px = st.rx;
				nx.py = st.ry;
				nx.held = 1'b1;
				nx.lock = st.tmode[TM_L];
				nx.dbc = st.deb;
				nx.scnt = 8'h0;
			end
		end
		// Calibration wait, ended by a touch or by the timeout
		if (cal_start) begin
			nx.cact = 1'b1;
			nx.csec = st.calto;
			nx.cms = 10'h0;
		end else if (st.cact) begin
			if (st.tv) begin
				nx.cact = 1'b0;
			end else if (st.csec == 8'h0) begin
				nx.cact = 1'b0;
				nx.cto = 1'b1;
			end else if (st.tick) begin
				nx.cms = st.cms + 10'h1;
				if (st.cms == MS_PER_S) begin
					nx.cms = 10'h0;
					nx.csec = st.csec - 8'h1;
				end
			end
		end
		// Unsigned interpolation; a falling range gives negative polarity
		lvl_calc = 17'((32'(st.bmin) * 32'(FULL_SCALE) + 32'(st.bcmd) * 32'(st.bmax)
			- 32'(st.bcmd) * 32'(st.bmin)) / 32'(FULL_SCALE));
		nx.lvl = lvl_calc[7:0];
		// Low class divides the PWM step to suit enable-driven inverters
		nx.ppre = st.ppre + 8'h1;
		if (!st.pcls || st.ppre == PWM_LOW_DIV) begin
			nx.ppre = 8'h0;
			nx.pcnt = st.pcnt + 8'h1;
		end
		nx.pwm = (st.pcnt < st.lvl);
		nx.blen = st.pol ? backlight_on : !backlight_on;
		nx.fa = st.orient[1];
		nx.fb = st.orient[0];
		// Notification serializer; one message at a time
		upper = note_kind & ~CASE_BIT;
		if (st.txv && tx_ready) begin
			if (st.nptr + 4'h1 == st.nlen) begin
				nx.txv = 1'b0;
			end else begin
				nx.nptr = st.nptr + 4'h1;
			end
		end
		if (!st.txv && note_valid) begin
			nx.nptr = 4'h0;
			nx.txv = 1'b1;
			if (st.bin) begin
				nx.nb[0] = upper;
				nx.nb[1] = note_index;
				nx.nb[2] = note_state;
				nx.nlen = note_has_state ? 4'h3 : 4'h2;
			end else begin
				nx.nb[0] = note_kind;
				k = 1;
				if (note_index >= 8'd100) begin
					nx.nb[k] = dig(note_index / 8'd100);
					k = k + 1;
				end
				if (note_index >= 8'd10) begin
					nx.nb[k] = dig((note_index / 8'd10) % 8'd10);
					k = k + 1;
				end
				nx.nb[k] = dig(note_index % 8'd10);
				k = k + 1;
				if (note_has_state) begin
					nx.nb[k] = CH_SPACE;
					k = k + 1;
					if (note_state >= 8'd100) begin
						nx.nb[k] = dig(note_state / 8'd100);
						k = k + 1;
					end
					if (note_state >= 8'd10) begin
						nx.nb[k] = dig((note_state / 8'd10) % 8'd10);
						k = k + 1;
					end
					nx.nb[k] = dig(note_state % 8'd10);
					k = k + 1;
				end
				nx.nb[k] = CH_RET;
				nx.nlen = 4'(k + 1);
			end
		end
		// Pointer stops on the last byte, so the output byte never indexes past the buffer
		nx.txd = nx.nb[nx.nptr];
		nx.nrdy = !nx.txv;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.rdy <= 1'b1;
			st.nrdy <= 1'b1;
			st.esc <= ESC_RST;
			st.deb <= DEBOUNCE_RST_MS;
			st.smp <= SAMPLES_RST;
			st.span <= SPAN_RST;
			st.calto <= CALTO_RST;
			st.bmax <= BMAX_RST;
			st.bmin <= BMIN_RST;
		end else begin
			st <= nx;
		end
	end

	assign hreadyout = st.rdy;
	assign hresp = 1'b0 & st.rdy;
	assign hrdata = st.rd;
	assign cmd_valid = st.cv;
	assign cmd_data = st.cd;
	assign ctl_port_aux = st.act;
	assign nv_store = st.nv;
	assign note_ready = st.nrdy;
	assign tx_valid = st.txv;
	assign tx_data = st.txd;
	assign touch_valid = st.tv;
	assign touch_release = st.trel;
	assign touch_lockout = st.lock;
	assign touch_pos_x = st.px;
	assign touch_pos_y = st.py;
	assign cal_timeout = st.cto;
	assign backlight_en = st.blen;
	assign backlight_pwm = st.pwm;
	assign panel_flip_a = st.fa;
	assign panel_flip_b = st.fb;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_esc_run_end;
		in_v && !wr_en && in_d == st.esc && st.ecnt == ESC_RUN_LAST;
	endsequence
	property p_esc_switch;
		s_esc_run_end |=> st.act == $past(in_aux) && st.temp && st.ecnt == 2'h0;
	endproperty
	a_esc_switch: assert property (p_esc_switch) else $error("escape run no switch");
	property p_esc_restart;
		in_v && !wr_en && in_d != st.esc |=> st.ecnt == 2'h0;
	endproperty
	a_esc_restart: assert property (p_esc_restart) else $error("escape count kept");
	property p_cmd_active;
		main_rx_valid && !st.act |=> cmd_valid && cmd_data == $past(main_rx_data);
	endproperty
	a_cmd_active: assert property (p_cmd_active) else $error("command byte lost");
	property p_cmd_only_active;
		cmd_valid |-> $past(main_rx_valid && !st.act || aux_rx_valid && st.act);
	endproperty
	a_cmd_only_active: assert property (p_cmd_only_active) else $error("bad source");
	property p_revert;
		do_rev |=> st.act == $past(st.prev) && !st.temp;
	endproperty
	a_revert: assert property (p_revert) else $error("revert failed");
	property p_esc_range;
		wr_esc && (hwdata[7:0] < ESC_MIN || hwdata[7:0] > ESC_MAX) |=> $stable(st.esc);
	endproperty
	a_esc_range: assert property (p_esc_range) else $error("bad escape taken");
	property p_flip;
		##1 panel_flip_a == $past(st.orient[1]) && panel_flip_b == $past(st.orient[0]);
	endproperty
	a_flip: assert property (p_flip) else $error("flip outputs wrong");
	property p_bl_pol;
		##1 backlight_en == ($past(st.pol) ~^ $past(backlight_on)) ;
	endproperty
	a_bl_pol: assert property (p_bl_pol) else $error("enable polarity wrong");
	property p_debounce;
		touch_valid |-> $past(st.dbc) == 16'h0 && st.dbc == $past(st.deb);
	endproperty
	a_debounce: assert property (p_debounce) else $error("debounce broken");
	property p_bin_head;
		note_valid && note_ready && st.bin |=> tx_valid && tx_data == $past(upper)
			&& st.nlen == ($past(note_has_state) ? 4'h3 : 4'h2);
	endproperty
	a_bin_head: assert property (p_bin_head) else $error("binary head wrong");
	property p_asc_head;
		note_valid && note_ready && !st.bin |=> tx_data == $past(note_kind)
			&& st.nb[st.nlen - 4'h1] == CH_RET;
	endproperty
	a_asc_head: assert property (p_asc_head) else $error("text notify wrong");
endmodule // dmsc_top
`default_nettype wire

// file: src/dmsc_pkg.sv
// Package for the display module setup command block
`default_nettype none
package dmsc_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PORT = 8'h04;
	localparam logic [7:0] OFS_ESC = 8'h08;
	localparam logic [7:0] OFS_TYPEMATIC = 8'h0c;
	localparam logic [7:0] OFS_DEBOUNCE = 8'h10;
	localparam logic [7:0] OFS_BRIGHT = 8'h14;
	localparam logic [7:0] OFS_TOUCH = 8'h18;
	localparam logic [7:0] OFS_PANEL = 8'h1c;
	localparam logic [7:0] OFS_CONFIG = 8'h20;
	// CTRL fields
	localparam int CTRL_BIN = 0;
	localparam int CTRL_SWAP = 1;
	localparam int CTRL_POL = 2;
	localparam int CTRL_PWMCLS = 3;
	localparam int CTRL_ORIENT = 4;
	localparam int CTRL_TMODE = 8;
	// Touch option bits: standard, lockout, pressure, wander
	localparam int TM_L = 1;
	localparam int TM_P = 2;
	localparam int TM_W = 3;
	// PORT write command bits
	localparam int PC_MAIN = 0;
	localparam int PC_AUX = 1;
	localparam int PC_REVERT = 2;
	localparam logic [7:0] ESC_RST = 8'h0d;
	localparam logic [7:0] ESC_MIN = 8'h01;
	localparam logic [7:0] ESC_MAX = 8'h7e;
	localparam logic [1:0] ESC_RUN_LAST = 2'h2;
	localparam logic [15:0] DEBOUNCE_RST_MS = 16'h0064;
	localparam logic [7:0] SAMPLES_RST = 8'h08;
	localparam logic [7:0] SPAN_RST = 8'h0c;
	localparam logic [7:0] CALTO_RST = 8'h05;
	localparam logic [7:0] BMAX_RST = 8'hff;
	localparam logic [7:0] BMIN_RST = 8'h00;
	localparam logic [9:0] MS_PER_S = 10'h3e7;
	localparam int CLK_MHZ = 250;
	localparam int MS_US = 1000;
	localparam int MS_CYCLES_DEF = CLK_MHZ * MS_US;
	localparam logic [7:0] PWM_LOW_DIV = 8'hff;
	localparam logic [7:0] FULL_SCALE = 8'hff;
	localparam logic [7:0] CH_RET = 8'h0d;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CASE_BIT = 8'h20;
	localparam logic [7:0] CH_STATE = 8'h73;
endpackage
`default_nettype wire

// file: dv/dmsc_host_model.sv
// Host model: sends bytes on the two serial ports and drains the device byte stream
`default_nettype none
module dmsc_host_model (
	input wire logic hclk,
	output logic main_rx_valid,
	output logic [7:0] main_rx_data,
	output logic aux_rx_valid,
	output logic [7:0] aux_rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic slow;
	logic [7:0] got[$];
	initial begin
		main_rx_valid = 1'b0;
		main_rx_data = 8'h00;
		aux_rx_valid = 1'b0;
		aux_rx_data = 8'h00;
		tx_ready = 1'b1;
		slow = 1'b0;
	end
	// Idle data lines show the inverse of the last byte, so a stale copy is never mistaken
	task automatic send(input logic aux, input logic [7:0] b);
		@(posedge hclk);
		if (aux) begin
			aux_rx_valid <= 1'b1;
			aux_rx_data <= b;
		end else begin
			main_rx_valid <= 1'b1;
			main_rx_data <= b;
		end
		@(posedge hclk);
		main_rx_valid <= 1'b0;
		aux_rx_valid <= 1'b0;
		if (aux)
			aux_rx_data <= ~b;
		else
			main_rx_data <= ~b;
	endtask
	// Slow mode stalls every other cycle to stretch each byte
	always @(posedge hclk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			got.push_back(tx_data);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
endmodule // dmsc_host_model
`default_nettype wire

// file: dv/tb_top.sv
// Testbench for the setup command block
`default_nettype none
module tb_top
	import dmsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, cmd_valid, ctl_port_aux, nv_store, note_ready, tx_valid, tx_ready;
	logic [7:0] cmd_data, tx_data, last_cmd, mrx_d, arx_d;
	logic mrx_v, arx_v, note_valid = 1'b0, note_has_state = 1'b0;
	logic [7:0] note_kind = 8'h0, note_index = 8'h0, note_state = 8'h0;
	logic touch_sample = 1'b0, touch_down = 1'b0, touch_valid, touch_release, touch_lockout;
	logic [9:0] touch_x = 10'h0, touch_y = 10'h0, pos_x, pos_y;
	logic cal_timeout, backlight_en, backlight_pwm, flip_a, flip_b, cal_start = 1'b0;
	int miscompares = 0, total_checks = 0, ncmd = 0, nnv = 0, ntouch = 0, cnt = 0;
	always #2 hclk = ~hclk;
	dmsc_top #(.MS_CYCLES(4), .CONFIG_SET(1'b1), .CONFIG_WORD(32'h5a5a0001)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.main_rx_valid(mrx_v), .main_rx_data(mrx_d), .aux_rx_valid(arx_v),
		.aux_rx_data(arx_d), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
		.ctl_port_aux(ctl_port_aux), .nv_store(nv_store), .note_valid(note_valid),
		.note_kind(note_kind), .note_index(note_index), .note_has_state(note_has_state),
		.note_state(note_state), .note_ready(note_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .touch_sample(touch_sample),
		.touch_down(touch_down), .touch_pressure_ok(1'b1), .touch_x(touch_x),
		.touch_y(touch_y), .touch_valid(touch_valid), .touch_release(touch_release),
		.touch_lockout(touch_lockout), .touch_pos_x(pos_x), .touch_pos_y(pos_y),
		.cal_start(cal_start), .cal_timeout(cal_timeout), .backlight_on(1'b1),
		.backlight_en(backlight_en), .backlight_pwm(backlight_pwm),
		.panel_flip_a(flip_a), .panel_flip_b(flip_b));
	dmsc_host_model u_host (.hclk(hclk), .main_rx_valid(mrx_v), .main_rx_data(mrx_d),
		.aux_rx_valid(arx_v), .aux_rx_data(arx_d), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready));
	always @(posedge hclk) begin
		if (cmd_valid === 1'b1) begin
			ncmd <= ncmd + 1;
			last_cmd <= cmd_data;
		end
		if (nv_store === 1'b1)
			nnv <= nnv + 1;
		if (touch_valid === 1'b1)
			ntouch <= ntouch + 1;
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Address phase held until hready, then data phase until hready; data taken there
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, hresp);
	endtask
	task automatic note(input logic [7:0] k, input logic [7:0] i, input logic h, input int n);
		u_host.got.delete();
		@(posedge hclk);
		note_valid <= 1'b1;
		note_kind <= k;
		note_index <= i;
		note_has_state <= h;
		note_state <= 8'h01;
		do @(posedge hclk); while (note_ready !== 1'b1);
		note_valid <= 1'b0;
		for (int c = 0; c < 200 && u_host.got.size() < n; c++)
			@(posedge hclk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		print_verdict();
	end
	initial begin
		automatic logic [7:0] esc_try[4] = '{8'h00, 8'h7f, 8'h01, 8'h7e};
		automatic logic [7:0] esc_exp[4] = '{8'h0d, 8'h0d, 8'h01, 8'h7e};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, OFS_ESC, 32'h0); chk("esc reset", 32'h0d, rd);
		ahb(1'b0, OFS_DEBOUNCE, 32'h0); chk("debounce reset", 32'h64, rd);
		ahb(1'b0, OFS_TOUCH, 32'h0); chk("touch reset", 32'h00050c08, rd[23:0]);
		ahb(1'b0, OFS_PORT, 32'h0); chk("port reset", 32'h0, rd[0]);
		ahb(1'b0, 8'h3c, 32'h0); chk("unmapped", 32'h0, rd);
		ahb(1'b0, OFS_PANEL, 32'h0); chk("panel", 32'h5a5a0001, rd);
		ahb(1'b0, OFS_CONFIG, 32'h0); chk("config", 32'h5a5a0001, rd);
		for (int k = 0; k < 4; k++) begin
			ahb(1'b1, OFS_ESC, {24'h0, esc_try[k]});
			ahb(1'b0, OFS_ESC, 32'h0); chk("esc range", esc_exp[k], rd);
		end
		ahb(1'b1, OFS_TYPEMATIC, 32'h000032c8);
		ahb(1'b0, OFS_TYPEMATIC, 32'h0); chk("typematic", 32'h32c8, rd[15:0]);
		$display("test registers done");
		u_host.send(1'b0, 8'h41);
		repeat (2) @(posedge hclk);
		chk("main cmd", 32'h41, last_cmd);
		foreach (esc_try[k]) u_host.send(1'b1, k == 2 ? 8'h41 : 8'h7e);
		u_host.send(1'b1, 8'h7e);
		repeat (2) @(posedge hclk);
		chk("broken run", 32'h0, ctl_port_aux);
		u_host.send(1'b1, 8'h7e);
		repeat (2) @(posedge hclk);
		chk("escape switch", 32'h1, ctl_port_aux);
		u_host.send(1'b0, 8'h42);
		u_host.send(1'b1, 8'h43);
		repeat (2) @(posedge hclk);
		chk("aux only", 32'h43, last_cmd);
		chk("cmd count", 32'h2, ncmd);
		ahb(1'b1, OFS_PORT, 32'h4);
		repeat (2) @(posedge hclk);
		chk("revert", 32'h0, ctl_port_aux);
		ahb(1'b1, OFS_PORT, 32'h2);
		repeat (2) @(posedge hclk);
		chk("select aux", 32'h1, ctl_port_aux);
		chk("stored", 32'h1, nnv > 0);
		ahb(1'b0, OFS_PORT, 32'h0); chk("port read", 32'h3, rd[1:0]);
		$display("test ports done");
		for (int o = 0; o < 4; o++) begin
			ahb(1'b1, OFS_CTRL, (o << 4) | (o[0] << 2));
			repeat (2) @(posedge hclk);
			chk("flip", o, {flip_a, flip_b});
			chk("enable pol", o[0], backlight_en);
		end
		ahb(1'b1, OFS_BRIGHT, 32'h00ffe600);
		ahb(1'b0, OFS_BRIGHT, 32'h0); chk("level top", 32'h0, rd[31:24]);
		ahb(1'b1, OFS_BRIGHT, 32'h0000e600);
		ahb(1'b0, OFS_BRIGHT, 32'h0); chk("level low", 32'he6, rd[31:24]);
		// A full PWM period holds exactly as many high cycles as the level
		cnt = 0;
		repeat (256) begin
			@(posedge hclk);
			cnt += backlight_pwm;
		end
		chk("pwm duty", 32'he6, cnt);
		$display("test outputs done");
		u_host.slow <= 1'b1;
		ahb(1'b1, OFS_CTRL, 32'h1);
		note(CH_STATE, 8'h05, 1'b1, 3);
		chk("bin bytes", 32'h530501,
			{u_host.got[0], u_host.got[1], u_host.got[2]});
		repeat (4) @(posedge hclk);
		chk("bin count", 3, u_host.got.size());
		ahb(1'b1, OFS_CTRL, 32'h0);
		note(8'h72, 8'h0c, 1'b0, 4);
		chk("text", 32'h7231320d,
			{u_host.got[0], u_host.got[1], u_host.got[2], u_host.got[3]});
		$display("test notify done");
		ahb(1'b1, OFS_DEBOUNCE, 32'h0);
		ahb(1'b1, OFS_TOUCH, 32'h00010402);
		ahb(1'b1, OFS_CTRL, 32'h202);
		@(posedge hclk);
		touch_down <= 1'b1;
		touch_x <= 10'h064;
		touch_y <= 10'h0c8;
		touch_sample <= 1'b1;
		@(posedge hclk);
		chk("early touch", 32'h0, ntouch);
		repeat (2) @(posedge hclk);
		touch_sample <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("touch taken", 32'h1, ntouch > 0);
		chk("swap", {10'h064, 10'h0c8}, {pos_y, pos_x});
		chk("lockout", 32'h1, touch_lockout);
		touch_down <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("release", 32'h1, touch_release);
		chk("unlock", 32'h0, touch_lockout);
		$display("test touch done");
		cal_start <= 1'b1;
		@(posedge hclk);
		cal_start <= 1'b0;
		cnt = 0;
		while (cal_timeout !== 1'b1 && cnt < 6000) begin
			@(posedge hclk);
			cnt++;
		end
		// One second is 1000 ticks of a 4-cycle millisecond
		chk("cal wait", 32'h1, cnt > 3990 && cnt < 4010);
		$display("test calibration done");
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
